// File: rtl/eec_rx_err_counters.sv
// Purpose: Clear-on-read E1 receive error counters behind an APB slave
// Assumes: Event inputs synchronous to sys_clk_i; one strobe per event
// Notes: One wait state per APB transfer; read side effects at capture edge
// Operation
// - Count framing alignment errors in sixteen bits
// - Upper alignment byte at index 0x902
// - Lower alignment byte at index 0x903
// - Reset to zero; upper byte read returns then clears the count
// - Severely errored frame count, index 0x904
// - Two consecutive bad alignment words, no LOF
// - Sync bit error count, upper byte 0x905
// - Sync bit error lower byte at 0x906
`timescale 1ns/1ps
`default_nettype none

`include "eec_rx_err_counters_regs.svh"

module eec_rx_err_counters
  import eec_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire eec_evt_t evt_i,
  input wire eec_apb_req_t apb_req_i,
  output eec_apb_rsp_t apb_rsp_o,
  output logic irq_o
);

  // Address decode, used for capture and for write effects
  function automatic eec_reg_t eec_dec(input logic [15:0] addr);
    logic [11:0] idx;
    eec_reg_t r;
    idx = addr[`EEC_IDX_MSB:`EEC_IDX_LSB];
    r = EEC_REG_NONE;
    if (addr[1:0] == 2'h0 && addr[15:14] == 2'h0) begin
      case (idx)
        `EEC_IDX_FAE_HI: r = EEC_REG_FAE_HI;
        `EEC_IDX_FAE_LO: r = EEC_REG_FAE_LO;
        `EEC_IDX_SEF: r = EEC_REG_SEF;
        `EEC_IDX_SBE_HI: r = EEC_REG_SBE_HI;
        `EEC_IDX_SBE_LO: r = EEC_REG_SBE_LO;
        `EEC_IDX_IRQ_STS: r = EEC_REG_IRQ_STS;
        `EEC_IDX_IRQ_MSK: r = EEC_REG_IRQ_MSK;
        default: r = EEC_REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Saturating byte increment
  function automatic logic [7:0] eec_inc8(input logic [7:0] v, input logic inc);
    logic [7:0] r;
    r = v;
    if (inc && v != 8'hff) begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  // Saturating halfword increment
  function automatic logic [15:0] eec_inc16(input logic [15:0] v, input logic inc);
    logic [15:0] r;
    r = v;
    if (inc && v != 16'hffff) begin
      r = v + 16'h0001;
    end
    return r;
  endfunction

  // Only the interrupt registers accept writes; the counters are read only
  function automatic logic eec_writable(input eec_reg_t r);
    logic ok;
    ok = 1'b0;
    case (r)
      EEC_REG_IRQ_STS: ok = 1'b1;
      EEC_REG_IRQ_MSK: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  eec_reg_t sel;
  logic acc_first;
  logic rd_go;
  logic wr_go;
  logic wr_ok;
  logic sts_wr;
  logic msk_wr;
  logic sef_rd;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  logic fae_ev;
  logic sbe_ev;
  logic sef_ev;
  logic fas_prev_err_q;
  logic fas_prev_err_d;

  logic [`EEC_NUM_CNT16-1:0] cnt_inc;
  logic [`EEC_NUM_CNT16-1:0] hi_rd;
  logic [`EEC_NUM_CNT16-1:0] lo_rd;
  logic [15:0] cnt16_q [`EEC_NUM_CNT16];
  logic [15:0] cnt16_d [`EEC_NUM_CNT16];
  logic [7:0] snap_q [`EEC_NUM_CNT16];
  logic [`EEC_NUM_CNT16-1:0] snap_vld_q;
  logic [7:0] hi_byte [`EEC_NUM_CNT16];
  logic [7:0] lo_byte [`EEC_NUM_CNT16];
  logic [7:0] sef_cnt_q;
  logic [7:0] sef_cnt_d;

  logic [`EEC_IRQ_W-1:0] irq_sts_q;
  logic [`EEC_IRQ_W-1:0] irq_sts_d;
  logic [`EEC_IRQ_W-1:0] irq_msk_q;
  logic [`EEC_IRQ_W-1:0] irq_set;
  logic [`EEC_IRQ_W-1:0] irq_clr;
  logic irq_q;
  logic irq_pend;

  // APB phases: capture on the first access cycle, complete on the next
  assign sel = eec_dec(apb_req_i.paddr);
  assign acc_first = apb_req_i.psel & apb_req_i.penable & ~pready_q;
  assign rd_go = acc_first & ~apb_req_i.pwrite;
  assign wr_go = apb_req_i.psel & apb_req_i.penable & pready_q & apb_req_i.pwrite;

  // Register strobes, decoded once
  assign wr_ok = wr_go & eec_writable(sel);
  assign sts_wr = wr_ok && sel == EEC_REG_IRQ_STS;
  assign msk_wr = wr_ok && sel == EEC_REG_IRQ_MSK;
  assign sef_rd = rd_go && sel == EEC_REG_SEF;

  // Framer events
  assign fae_ev = evt_i.fas_check & evt_i.fas_err;
  assign sbe_ev = evt_i.sync_bit_err;
  assign sef_ev = evt_i.fas_check & evt_i.fas_err & fas_prev_err_q & ~evt_i.lof;

  assign cnt_inc[`EEC_CNT_FAE] = fae_ev;
  assign cnt_inc[`EEC_CNT_SBE] = sbe_ev;
  assign hi_rd[`EEC_CNT_FAE] = rd_go && sel == EEC_REG_FAE_HI;
  assign hi_rd[`EEC_CNT_SBE] = rd_go && sel == EEC_REG_SBE_HI;
  assign lo_rd[`EEC_CNT_FAE] = rd_go && sel == EEC_REG_FAE_LO;
  assign lo_rd[`EEC_CNT_SBE] = rd_go && sel == EEC_REG_SBE_LO;

  // Consecutive errored alignment word tracker
  always_comb begin
    fas_prev_err_d = fas_prev_err_q;
    if (evt_i.fas_check) begin
      if (evt_i.lof) begin
        fas_prev_err_d = 1'b0;
      end else if (evt_i.fas_err) begin
        // A counted pair starts over; a third bad word needs a fourth
        fas_prev_err_d = ~fas_prev_err_q;
      end else begin
        fas_prev_err_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fas_prev_err_q <= 1'b0;
    end else begin
      fas_prev_err_q <= fas_prev_err_d;
    end
  end

  // Sixteen-bit counters with low-byte snapshot on upper-byte read
  genvar gi;
  generate
    for (gi = 0; gi < `EEC_NUM_CNT16; gi++) begin : g_cnt16
      always_comb begin
        if (hi_rd[gi]) begin
          // Whole count moves out; a same-cycle event starts the next count
          cnt16_d[gi] = {15'h0000, cnt_inc[gi]};
        end else begin
          cnt16_d[gi] = eec_inc16(cnt16_q[gi], cnt_inc[gi]);
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          cnt16_q[gi] <= `EEC_CNT16_RST;
        end else begin
          cnt16_q[gi] <= cnt16_d[gi];
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          snap_q[gi] <= `EEC_BYTE_RST;
        end else if (hi_rd[gi]) begin
          snap_q[gi] <= cnt16_q[gi][7:0];
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          snap_vld_q[gi] <= 1'b0;
        end else if (hi_rd[gi]) begin
          snap_vld_q[gi] <= 1'b1;
        end else if (lo_rd[gi]) begin
          snap_vld_q[gi] <= 1'b0;
        end
      end

      // Bytes as the host sees them; a pending snapshot stands in for the low byte
      assign hi_byte[gi] = cnt16_q[gi][15:8];
      assign lo_byte[gi] = snap_vld_q[gi] ? snap_q[gi] : cnt16_q[gi][7:0];
    end
  endgenerate

  // Severely errored frame counter
  always_comb begin
    if (sef_rd) begin
      sef_cnt_d = {7'h00, sef_ev};
    end else begin
      sef_cnt_d = eec_inc8(sef_cnt_q, sef_ev);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sef_cnt_q <= `EEC_CNT8_RST;
    end else begin
      sef_cnt_q <= sef_cnt_d;
    end
  end

  // Read data and error response
  always_comb begin
    prdata_d = `EEC_DATA_RST;
    pslverr_d = 1'b0;
    case (sel)
      EEC_REG_FAE_HI: begin
        prdata_d = {24'h000000, hi_byte[`EEC_CNT_FAE]};
      end
      EEC_REG_FAE_LO: begin
        prdata_d = {24'h000000, lo_byte[`EEC_CNT_FAE]};
      end
      EEC_REG_SEF: begin
        prdata_d = {24'h000000, sef_cnt_q};
      end
      EEC_REG_SBE_HI: begin
        prdata_d = {24'h000000, hi_byte[`EEC_CNT_SBE]};
      end
      EEC_REG_SBE_LO: begin
        prdata_d = {24'h000000, lo_byte[`EEC_CNT_SBE]};
      end
      EEC_REG_IRQ_STS: begin
        prdata_d = {29'h00000000, irq_sts_q};
      end
      EEC_REG_IRQ_MSK: begin
        prdata_d = {29'h00000000, irq_msk_q};
      end
      default: begin
        pslverr_d = 1'b1;
      end
    endcase
    // Counters are read only
    if (apb_req_i.pwrite && !eec_writable(sel)) begin
      pslverr_d = 1'b1;
    end
    if (apb_req_i.pwrite) begin
      prdata_d = `EEC_DATA_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
    end
  end

  // Response fields stand only in the pready cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= `EEC_DATA_RST;
    end else if (acc_first) begin
      prdata_q <= prdata_d;
    end else begin
      prdata_q <= `EEC_DATA_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pslverr_q <= 1'b0;
    end else if (acc_first) begin
      pslverr_q <= pslverr_d;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Interrupt status: set wins over a same-cycle write-one clear
  assign irq_set[`EEC_IRQ_FAE_BIT] = fae_ev;
  assign irq_set[`EEC_IRQ_SEF_BIT] = sef_ev;
  assign irq_set[`EEC_IRQ_SBE_BIT] = sbe_ev;
  assign irq_clr = sts_wr ? apb_req_i.pwdata[`EEC_IRQ_W-1:0] : `EEC_IRQ_RST;
  assign irq_sts_d = irq_set | (irq_sts_q & ~irq_clr);
  assign irq_pend = |(irq_sts_d & irq_msk_q);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_sts_q <= `EEC_IRQ_RST;
    end else begin
      irq_sts_q <= irq_sts_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_msk_q <= `EEC_IRQ_RST;
    end else if (msk_wr) begin
      irq_msk_q <= apb_req_i.pwdata[`EEC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_pend;
    end
  end

  assign apb_rsp_o.pready = pready_q;
  assign apb_rsp_o.pslverr = pslverr_q;
  assign apb_rsp_o.prdata = prdata_q;
  assign irq_o = irq_q;

endmodule

`default_nettype wire

// File: rtl/eec_rx_err_counters_regs.svh
// Purpose: Register indices, field positions, reset values for the E1 rx error counters
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef EEC_RX_ERR_COUNTERS_REGS_SVH
`define EEC_RX_ERR_COUNTERS_REGS_SVH

// Register indices (byte address = index * 4)
`define EEC_IDX_FAE_HI 12'h902
`define EEC_IDX_FAE_LO 12'h903
`define EEC_IDX_SEF 12'h904
`define EEC_IDX_SBE_HI 12'h905
`define EEC_IDX_SBE_LO 12'h906
`define EEC_IDX_IRQ_STS 12'h910
`define EEC_IDX_IRQ_MSK 12'h911

// Address layout
`define EEC_ADDR_W 16
`define EEC_IDX_LSB 2
`define EEC_IDX_MSB 13

// Interrupt status / mask bit positions
`define EEC_IRQ_FAE_BIT 0
`define EEC_IRQ_SEF_BIT 1
`define EEC_IRQ_SBE_BIT 2
`define EEC_IRQ_W 3

// Reset values
`define EEC_CNT16_RST 16'h0000
`define EEC_CNT8_RST 8'h00
`define EEC_BYTE_RST 8'h00
`define EEC_IRQ_RST 3'h0
`define EEC_DATA_RST 32'h0000_0000

// Counter indices within the 16-bit counter array
`define EEC_CNT_FAE 0
`define EEC_CNT_SBE 1
`define EEC_NUM_CNT16 2

`endif

// File: rtl/eec_pkg.sv
// Purpose: Types shared by the E1 rx error counter block
// Assumes: APB with 32-bit data
// Notes: Constants live in eec_rx_err_counters_regs.svh
package eec_pkg;

  // Error strobes from the receive framer
  typedef struct packed {
    logic fas_check;
    logic fas_err;
    logic sync_bit_err;
    logic lof;
  } eec_evt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } eec_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eec_apb_rsp_t;

  typedef enum logic [2:0] {
    EEC_REG_NONE,
    EEC_REG_FAE_HI,
    EEC_REG_FAE_LO,
    EEC_REG_SEF,
    EEC_REG_SBE_HI,
    EEC_REG_SBE_LO,
    EEC_REG_IRQ_STS,
    EEC_REG_IRQ_MSK
  } eec_reg_t;

endpackage

// File: testbench/eec_rx_err_counters_props.sv
// Purpose: APB timing and reset checks for eec_rx_err_counters
// Assumes: One wait state per transfer
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module eec_rx_err_counters_props
  import eec_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire eec_evt_t evt_i,
  input wire eec_apb_req_t apb_req_i,
  input wire eec_apb_rsp_t apb_rsp_o,
  input wire logic irq_o
);
  wire logic rdy = apb_rsp_o.pready;
  wire logic err = apb_rsp_o.pslverr;
  wire logic [31:0] rd = apb_rsp_o.prdata;
  wire logic acc = apb_req_i.psel && apb_req_i.penable;
  wire logic [11:0] ix = apb_req_i.paddr[13:2];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RDY_LAT: assert property ($rose(acc) |-> !rdy ##1 rdy)
    else $error("pready not after one wait");
  AST_RDY_PULSE: assert property (rdy |=> !rdy)
    else $error("pready longer than one cycle");
  AST_RDY_CAUSE: assert property (rdy |-> acc && $past(acc))
    else $error("pready without access");
  AST_IDLE_ZERO: assert property (!rdy |-> rd == 32'h0 && !err)
    else $error("response outside pready");
  AST_BYTE: assert property (rdy |-> rd[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_UNMAP: assert property ($rose(acc) && ix == 12'h940 |=> err && rd == 32'h0)
    else $error("unmapped access not refused");
  AST_WR_RO: assert property ($rose(acc) && apb_req_i.pwrite
    && ix inside {[12'h902:12'h906]} |=> err)
    else $error("counter write not refused");
  AST_RST: assert property (disable iff (1'b0) !rst_n_i |=> !rdy && !irq_o)
    else $error("outputs not clear after reset");
  COV_RD: cover property (rdy && rd != 32'h0);
  COV_IRQ: cover property ($rose(irq_o));
  COV_ERR: cover property (rdy && err);
endmodule
bind eec_rx_err_counters eec_rx_err_counters_props u_props (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .evt_i(evt_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
  .irq_o(irq_o));
`default_nettype wire

// File: testbench/eec_rx_err_counters_tb_top.sv
// Purpose: Self-checking bench for eec_rx_err_counters
// Assumes: Model predicts reads at the first access edge
// Notes: Random framer events run during reads
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module eec_rx_err_counters_tb_top
  import eec_pkg::*;
;
  logic clk, rst_n, ev_on, sat, pp, sfv, sbv, wp, ex_e, irq;
  logic [31:0] ex_d, wd, rnd;
  logic [11:0] ix, wa;
  logic [2:0] st, mk;
  eec_evt_t evt;
  eec_apb_req_t rq;
  eec_apb_rsp_t rsp;
  int fae, sbe, sef, sf, sb, prv, n_fail, checks_done, cyc, seed;
  logic [15:0] regs [6] = '{16'h2408, 16'h240c, 16'h2410, 16'h2414, 16'h2418, 16'h2440};
  eec_rx_err_counters u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .evt_i(evt),
    .apb_req_i(rq), .apb_rsp_o(rsp), .irq_o(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    rnd = $random(seed);
    if (sat) evt <= 4'he;
    else if (ev_on) evt <= {rnd[0], rnd[1] | rnd[2], rnd[6], rnd[3] & rnd[4]};
    else evt <= '0;
  end
  // Reference model, sampled at each edge
  always @(posedge clk) begin
    if (!rst_n) begin
      {fae, sbe, sef, sf, sb, prv} = '0;
      {pp, sfv, sbv, wp, st, mk} = '0;
    end else begin
      if (wp) begin
        if (wa == 12'h910) st = st & ~wd[2:0];
        if (wa == 12'h911) mk = wd[2:0];
        wp = 1'b0;
      end
      if (rq.psel && rq.penable && !pp) begin
        ix = rq.paddr[13:2];
        ex_d = '0;
        ex_e = 1'b0;
        if (rq.pwrite) begin
          ex_e = !(ix == 12'h910 || ix == 12'h911);
          wp = !ex_e;
          wa = ix;
          wd = rq.pwdata;
        end else case (ix)
          12'h902: begin ex_d = fae >> 8; sf = fae & 255; sfv = 1'b1; fae = 0; end
          12'h903: begin ex_d = sfv ? sf : fae & 255; sfv = 1'b0; end
          12'h904: begin ex_d = sef; sef = 0; end
          12'h905: begin ex_d = sbe >> 8; sb = sbe & 255; sbv = 1'b1; sbe = 0; end
          12'h906: begin ex_d = sbv ? sb : sbe & 255; sbv = 1'b0; end
          12'h910: ex_d = st;
          12'h911: ex_d = mk;
          default: ex_e = 1'b1;
        endcase
      end
      pp = rq.psel && rq.penable;
      if (evt.fas_check && evt.fas_err) begin
        fae += (fae < 65535);
        st[0] = 1'b1;
      end
      if (evt.fas_check) begin
        if (evt.lof || !evt.fas_err) prv = 0;
        else if (prv == 1) begin
          sef += (sef < 255);
          prv = 0;
          st[1] = 1'b1;
        end else prv = 1;
      end
      if (evt.sync_bit_err) begin
        sbe += (sbe < 65535);
        st[2] = 1'b1;
      end
    end
  end
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    rq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    rq.penable <= 1'b1;
    @(posedge clk);
    // pready ends this wait; if it never comes, only the bench timeout does
    while (rsp.pready !== 1'b1) begin
      @(posedge clk);
    end
    `CHK("prdata", ex_d, rsp.prdata)
    `CHK("pslverr", ex_e, rsp.pslverr)
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_all();
    foreach (regs[i]) apb(1'b0, regs[i], 32'h0);
  endtask
  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    {rst_n, ev_on, sat} = '0;
    rq = '0;
    seed = 19;
    {n_fail, checks_done, cyc} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_all();
    apb(1'b0, 16'h2444, 32'h0);
    apb(1'b0, 16'h2500, 32'h0);
    apb(1'b1, 16'h2408, 32'hff);
    apb(1'b1, 16'h2444, 32'h7);
    ev_on <= 1'b1;
    repeat (2) begin
      repeat (1000) @(posedge clk);
      rd_all();
    end
    apb(1'b0, 16'h240c, 32'h0);
    ev_on <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("irq", (st & mk) != 3'h0, irq)
    apb(1'b1, 16'h2440, 32'h7);
    repeat (4) @(posedge clk);
    `CHK("irq", (st & mk) != 3'h0, irq)
    rd_all();
    apb(1'b1, 16'h2444, 32'h0);
    ev_on <= 1'b1;
    repeat (50) @(posedge clk);
    ev_on <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("irq", (st & mk) != 3'h0, irq)
    apb(1'b1, 16'h2444, 32'h7);
    repeat (4) @(posedge clk);
    `CHK("irq", (st & mk) != 3'h0, irq)
    sat <= 1'b1;
    repeat (66000) @(posedge clk);
    sat <= 1'b0;
    repeat (4) @(posedge clk);
    rd_all();
    results();
  end
endmodule
`default_nettype wire
